// ==== pkg/decim_pkg.sv ====
// Shared constants and carrier types of the decimating filter control block
`default_nettype none
package decim_pkg;
    localparam int SAMPLE_W = 16;
    localparam int COEF_W = 16;
    localparam int ACC_W = 40;
    localparam int RATE_W = 8;
    localparam int SHIFT_W = 6;
    localparam int STAGE_W = 3;
    localparam int FRATE_W = 5;
    localparam logic [FRATE_W-1:0] FIR_RATE_MAX = 5'h10;
    localparam logic [SHIFT_W-1:0] SHIFT_PASS_NTH = 6'h32;
    localparam logic [RATE_W-1:0] RATE_BYPASS = 8'h01;
    localparam logic [STAGE_W-1:0] STAGES_BYPASS = 3'h0;
    localparam int OUT_LSB = 15;

    typedef struct packed {
        logic [RATE_W-1:0] coarse_rate;
        logic [STAGE_W-1:0] stages;
        logic [SHIFT_W-1:0] gain_shift;
        logic [FRATE_W-1:0] fir_rate;
        logic fir_disable;
    } cfg_t;

    localparam cfg_t CFG_RESET = '{coarse_rate: 8'h01, stages: 3'h0, gain_shift: 6'h00,
                                   fir_rate: 5'h01, fir_disable: 1'b0};
endpackage
`default_nettype wire

// ==== logic/decim_ctrl.sv ====
// Two-stage decimating filter: coarse decimator followed by symmetric FIR
//
// Operation
// - After FIR start, coefficient writes are discarded; stored coefficients stay unchanged.
// - Coarse stage bypassed only with coarse rate 1 and stage count 0.
// - Once started, coarse stage runs on; only reset stops it.
// - Each output result holds until the next output-valid strobe replaces it.
// - Gain shift 50 with stage count 0 passes every Nth sample unfiltered through the coarse stage.
// - FIR decimation rate is limited to at most 16.
`default_nettype none
module decim_ctrl #(
    parameter int HALF_TAPS = 4
) (
    // Clock, reset, enable
    input wire logic CLK_I,
    input wire logic RESET_I,
    input wire logic CE_I,
    // Control
    input wire logic [1:0] START_N_I,
    input wire decim_pkg::cfg_t CFG_I,
    input wire logic COEF_WE_I,
    input wire logic [$clog2(HALF_TAPS)-1:0] COEF_ADDR_I,
    input wire logic [decim_pkg::COEF_W-1:0] COEF_DATA_I,
    // Sample stream
    input wire logic SAMPLE_VALID_I,
    input wire logic signed [decim_pkg::SAMPLE_W-1:0] SAMPLE_I,
    // Results and status
    output logic DATA_VALID_O,
    output logic signed [decim_pkg::SAMPLE_W-1:0] DATA_O,
    output logic COARSE_RUN_O,
    output logic FIR_RUN_O,
    output logic RATE_CLAMP_O
);
    localparam int LINE = 2 * HALF_TAPS - 1;

    ////////////////////////////////////////////////////////////////////////////
    // Configuration and run state
    decim_pkg::cfg_t cfg_q;
    logic coarse_run_q, fir_run_q;
    logic signed [decim_pkg::COEF_W-1:0] coef_q [HALF_TAPS];

    // Config frozen once the coarse stage runs, so a glitching bus cannot retune a live filter
    always_ff @(posedge CLK_I) begin
        if (RESET_I) begin
            cfg_q <= decim_pkg::CFG_RESET;
            coarse_run_q <= 1'b0;
            fir_run_q <= 1'b0;
        end else if (CE_I) begin
            if (!coarse_run_q) begin
                cfg_q <= CFG_I;
            end
            if (!START_N_I[0]) begin
                coarse_run_q <= 1'b1;
            end
            if (!START_N_I[1]) begin
                fir_run_q <= 1'b1;
            end
        end
    end

    wire coef_wr = CE_I && COEF_WE_I && !fir_run_q;
    always_ff @(posedge CLK_I) begin
        if (coef_wr) begin
            coef_q[COEF_ADDR_I] <= COEF_DATA_I;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Coarse decimating stage
    wire bypass = (cfg_q.coarse_rate == decim_pkg::RATE_BYPASS)
        && (cfg_q.stages == decim_pkg::STAGES_BYPASS);
    wire pass_nth = (cfg_q.gain_shift == decim_pkg::SHIFT_PASS_NTH)
        && (cfg_q.stages == decim_pkg::STAGES_BYPASS);
    wire [decim_pkg::RATE_W-1:0] rate_eff =
        (cfg_q.coarse_rate == '0) ? decim_pkg::RATE_BYPASS : cfg_q.coarse_rate;

    logic [decim_pkg::RATE_W-1:0] cnt_q;
    logic signed [decim_pkg::ACC_W-1:0] acc_q;
    logic coarse_vld_q;
    logic signed [decim_pkg::SAMPLE_W-1:0] coarse_dat_q;

    wire take = CE_I && coarse_run_q && SAMPLE_VALID_I;
    wire last = (cnt_q == rate_eff - 8'h01);
    wire signed [decim_pkg::ACC_W-1:0] acc_sum = acc_q + decim_pkg::ACC_W'(SAMPLE_I);
    wire signed [decim_pkg::ACC_W-1:0] acc_scaled = acc_sum >>> cfg_q.gain_shift;
    // Stage count above zero is modelled as one integrate-and-dump section
    wire signed [decim_pkg::SAMPLE_W-1:0] coarse_next =
        (bypass || pass_nth) ? SAMPLE_I : acc_scaled[decim_pkg::SAMPLE_W-1:0];

    always_ff @(posedge CLK_I) begin
        if (RESET_I) begin
            cnt_q <= '0;
            acc_q <= '0;
            coarse_vld_q <= 1'b0;
            coarse_dat_q <= '0;
        end else if (CE_I) begin
            coarse_vld_q <= take && (bypass || last);
            if (take) begin
                cnt_q <= (bypass || last) ? '0 : cnt_q + 8'h01;
                acc_q <= (bypass || last) ? '0 : acc_sum;
                if (bypass || last) begin
                    coarse_dat_q <= coarse_next;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Symmetric FIR stage
    wire [decim_pkg::FRATE_W-1:0] frate_eff =
        (cfg_q.fir_rate > decim_pkg::FIR_RATE_MAX) ? decim_pkg::FIR_RATE_MAX :
        (cfg_q.fir_rate == '0) ? 5'h01 : cfg_q.fir_rate;

    logic signed [decim_pkg::SAMPLE_W-1:0] line_q [LINE];
    logic [decim_pkg::FRATE_W-1:0] fcnt_q;
    logic signed [decim_pkg::ACC_W-1:0] part [HALF_TAPS];
    logic signed [decim_pkg::ACC_W-1:0] fir_sum;

    // Only the unique half is stored; mirrored taps share one product
    genvar k;
    generate
        for (k = 0; k < HALF_TAPS; k++) begin : g_tap
            wire signed [decim_pkg::SAMPLE_W:0] pre = (k == HALF_TAPS - 1) ?
                (decim_pkg::SAMPLE_W+1)'(line_q[k]) :
                (decim_pkg::SAMPLE_W+1)'(line_q[k]) + (decim_pkg::SAMPLE_W+1)'(line_q[LINE-1-k]);
            // Both operands widened first: a cast of the bare product keeps only 17 bits
            assign part[k] = decim_pkg::ACC_W'(pre) * decim_pkg::ACC_W'(coef_q[k]);
        end
    endgenerate

    always_comb begin
        fir_sum = '0;
        for (int i = 0; i < HALF_TAPS; i++) begin
            fir_sum = fir_sum + part[i];
        end
    end

    wire fstep = CE_I && fir_run_q && coarse_vld_q;
    wire flast = (fcnt_q == frate_eff - 5'h01);

    always_ff @(posedge CLK_I) begin
        if (RESET_I) begin
            fcnt_q <= '0;
            for (int i = 0; i < LINE; i++) begin
                line_q[i] <= '0;
            end
        end else if (fstep) begin
            line_q[0] <= coarse_dat_q;
            for (int i = 1; i < LINE; i++) begin
                line_q[i] <= line_q[i-1];
            end
            fcnt_q <= flast ? '0 : fcnt_q + 5'h01;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Output holding registers
    wire fir_out = CE_I && fir_run_q && !cfg_q.fir_disable && fstep && flast;
    wire dis_out = CE_I && cfg_q.fir_disable && coarse_vld_q;
    wire out_new = fir_out || dis_out;
    wire signed [decim_pkg::SAMPLE_W-1:0] out_val = cfg_q.fir_disable ? coarse_dat_q :
        fir_sum[decim_pkg::OUT_LSB +: decim_pkg::SAMPLE_W];

    always_ff @(posedge CLK_I) begin
        if (RESET_I) begin
            DATA_VALID_O <= 1'b0;
            DATA_O <= '0;
            COARSE_RUN_O <= 1'b0;
            FIR_RUN_O <= 1'b0;
            RATE_CLAMP_O <= 1'b0;
        end else if (CE_I) begin
            DATA_VALID_O <= out_new;
            if (out_new) begin
                DATA_O <= out_val;
            end
            COARSE_RUN_O <= coarse_run_q;
            FIR_RUN_O <= fir_run_q;
            RATE_CLAMP_O <= cfg_q.fir_rate > decim_pkg::FIR_RATE_MAX;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Assertions
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (RESET_I);

    // Word aimed at by a refused write is compared with its value before that edge
    a_coef_write_lock: assert property (CE_I && COEF_WE_I && fir_run_q |=>
        coef_q[$past(COEF_ADDR_I)] == $past(coef_q[COEF_ADDR_I]))
        else $error("coefficient changed after start");
    a_fir_start_flag: assert property (CE_I && !START_N_I[1] |=> fir_run_q)
        else $error("fir start not latched");

    sequence s_bypass_take;
        take && bypass;
    endsequence
    a_bypass_passthru: assert property (s_bypass_take |=> coarse_vld_q
        && coarse_dat_q == $past(SAMPLE_I)) else $error("bypass did not pass sample");
    a_stage_one_dec: assert property (take && !bypass && !last |=> !coarse_vld_q)
        else $error("non-bypassed stage emitted early");
    a_coarse_run_sticky: assert property (coarse_run_q |=> coarse_run_q)
        else $error("coarse stage stopped without reset");
    a_output_held: assert property (!DATA_VALID_O |-> $stable(DATA_O))
        else $error("output changed without valid strobe");
    a_disable_passthru: assert property (dis_out |=> DATA_VALID_O
        && DATA_O == $past(coarse_dat_q))
        else $error("disabled fir did not pass coarse result");
    a_valid_pulse: assert property (CE_I && DATA_VALID_O && !out_new |=> !DATA_VALID_O)
        else $error("valid strobe stretched");
    a_nth_sample_pass: assert property (take && pass_nth && last |=> coarse_vld_q
        && coarse_dat_q == $past(SAMPLE_I)) else $error("nth sample not passed unfiltered");
    a_fir_rate_cap: assert property (frate_eff <= decim_pkg::FIR_RATE_MAX)
        else $error("fir rate above limit");
    a_rate_clamp_flag: assert property (CE_I && cfg_q.fir_rate > decim_pkg::FIR_RATE_MAX
        |=> RATE_CLAMP_O) else $error("rate clamp not flagged");
endmodule
`default_nettype wire

// ==== sim/host_model.sv ====
// Host model: loads config and coefficients, then starts the filter
`default_nettype none
module host_model #(
    parameter int HALF_TAPS = 4
) (
    // Control from the bench
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic go_i,
    input wire logic stop_i,
    input wire decim_pkg::cfg_t want_i,
    // Towards the filter
    output logic [1:0] start_n_o,
    output decim_pkg::cfg_t cfg_o,
    output logic we_o,
    output logic [$clog2(HALF_TAPS)-1:0] addr_o,
    output logic [decim_pkg::COEF_W-1:0] data_o
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        start_n_o = 2'b11;
        cfg_o = decim_pkg::CFG_RESET;
        we_o = 1'b0;
        addr_o = '0;
        data_o = '0;
    end
    // Releasing start must not stop a running filter
    always @(posedge stop_i) start_n_o = 2'b11;
    always @(posedge go_i) begin
        start_n_o = 2'b11;
        wait (!rst_i);
        @(negedge clk_i);
        cfg_o = want_i;
        cfg_o.fir_disable = 1'b0;
        @(negedge clk_i);
        cfg_o.fir_disable = 1'b1;
        for (int i = 0; i < HALF_TAPS; i++) begin
            we_o = 1'b1;
            addr_o = i[$clog2(HALF_TAPS)-1:0];
            data_o = 16'h0100;
            @(negedge clk_i);
        end
        we_o = 1'b0;
        data_o = ~data_o;
        cfg_o = want_i;
        @(negedge clk_i);
        start_n_o = 2'b00;
        // Late write after start must be discarded
        repeat (2) @(negedge clk_i);
        we_o = 1'b1;
        addr_o = '0;
        data_o = 16'h7fff;
        @(negedge clk_i);
        we_o = 1'b0;
    end
endmodule
`default_nettype wire

// ==== sim/decim_ctrl_test.sv ====
// Self-checking bench of the decimating filter control block
`default_nettype none
module decim_ctrl_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0, rst = 1'b1, go = 1'b0, stop = 1'b0, vld = 1'b0;
    logic ce = 1'b1, ce_s = 1'b1, fd_s = 1'b1;
    logic signed [15:0] hist [7];
    int fc = 0, fe = 1;
    logic we, dv, crun, frun, clamp;
    logic [1:0] start_n, aw;
    logic [15:0] cd;
    logic signed [15:0] smp = '0, dout, last = '0;
    decim_pkg::cfg_t want = decim_pkg::CFG_RESET, cfg;
    logic signed [15:0] exp_q[$];
    int error_cnt = 0, checked = 0, seed = 32'hdf4de367;
    initial forever #2 clk = ~clk;
    host_model #(.HALF_TAPS(4)) host_u (.clk_i(clk), .rst_i(rst), .go_i(go), .stop_i(stop),
        .want_i(want), .start_n_o(start_n), .cfg_o(cfg), .we_o(we), .addr_o(aw), .data_o(cd));
    decim_ctrl #(.HALF_TAPS(4)) dut_u (.CLK_I(clk), .RESET_I(rst), .CE_I(ce),
        .START_N_I(start_n), .CFG_I(cfg), .COEF_WE_I(we), .COEF_ADDR_I(aw),
        .COEF_DATA_I(cd), .SAMPLE_VALID_I(vld), .SAMPLE_I(smp), .DATA_VALID_O(dv),
        .DATA_O(dout), .COARSE_RUN_O(crun), .FIR_RUN_O(frun), .RATE_CLAMP_O(clamp));
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("FAIL %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic end_sim();
        $display("Counts: %0d compared, %0d mismatched", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // Results are matched in order; between strobes the output must hold
    // A strobe frozen by a low enable is the same result, so it is counted once
    always @(posedge clk) ce_s <= ce;
    always @(negedge clk) begin
        if (dv === 1'b1 && ce_s) begin
            if (exp_q.size() == 0) chk(16'h0000, 16'h0001);
            else chk(dout, exp_q.pop_front());
            last = dout;
        end else if (rst) last = '0;
        else chk(dout, last);
    end
    // Coarse result noted; with the FIR on, all seven taps weigh 16'h0100
    task automatic note(input logic signed [15:0] c);
        logic signed [39:0] hs;
        hs = '0;
        if (fd_s) begin
            exp_q.push_back(c);
        end else begin
            for (int j = 0; j < 7; j++) hs += hist[j];
            if (fc == fe - 1) exp_q.push_back(16'(hs >>> 7));
            fc = (fc == fe - 1) ? 0 : fc + 1;
            for (int j = 6; j > 0; j--) hist[j] = hist[j-1];
            hist[0] = c;
        end
    endtask
    task automatic run(input logic [7:0] rate, input logic [2:0] stg, input logic [5:0] sh,
            input logic [4:0] fr, input logic fd, input int n);
        logic signed [39:0] sum;
        logic signed [15:0] x;
        int k;
        sum = '0;
        want = '{coarse_rate: rate, stages: stg, gain_shift: sh, fir_rate: fr, fir_disable: fd};
        fd_s = fd;
        fe = (fr > 5'h10) ? 16 : (fr == 5'h00) ? 1 : int'(fr);
        fc = 0;
        for (int j = 0; j < 7; j++) hist[j] = '0;
        rst = 1'b1;
        // Go rises after the host is waiting, so its edge is never missed
        @(negedge clk);
        go = 1'b1;
        repeat (19) @(negedge clk);
        rst = 1'b0;
        go = 1'b0;
        for (k = 0; k < 40 && crun !== 1'b1; k++) @(negedge clk);
        chk({15'h0, frun}, 16'h0001);
        chk({15'h0, clamp}, {15'h0, fr > 5'h10});
        k = 0;
        for (int i = 0; i < n; i++) begin
            x = $random(seed);
            vld = 1'b0;
            // Random idle gaps mix back-to-back with spaced samples
            if (x[15]) begin
                ce = x[14];
                @(negedge clk);
                ce = 1'b1;
            end
            stop = (i >= n / 2);
            vld = 1'b1;
            smp = x;
            if (rate == 8'h01 && stg == 3'h0) note(x);
            else begin
                sum += x;
                k++;
                if (k == rate) begin
                    note((stg == 3'h0 && sh == 6'h32) ? x : 16'(sum >>> sh));
                    sum = '0;
                    k = 0;
                end
            end
            @(negedge clk);
        end
        vld = 1'b0;
        repeat (10) @(negedge clk);
        chk({15'h0, exp_q.size() == 0}, 16'h0001);
        chk({15'h0, crun}, 16'h0001);
        stop = 1'b0;
        $display("Test done: rate %0d stages %0d shift %0d", rate, stg, sh);
    endtask
    initial begin
        run(8'h01, 3'h0, 6'h00, 5'h10, 1'b1, 24);
        run(8'h01, 3'h1, 6'h01, 5'h01, 1'b1, 16);
        run(8'h03, 3'h1, 6'h02, 5'h11, 1'b1, 24);
        run(8'h04, 3'h0, 6'h32, 5'h04, 1'b1, 24);
        run(8'h02, 3'h1, 6'h01, 5'h03, 1'b0, 24);
        end_sim();
    end
    initial begin
        #20000;
        error_cnt++;
        end_sim();
    end
endmodule
`default_nettype wire
